// [inc/ptt_pkg.sv]
// constants and types shared by the pilot transfer trip scheme logic
package ptt_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PU_DLY_OFS = 8'h04;
    localparam logic [7:0] PO_DLY_OFS = 8'h08;
    localparam logic [7:0] GUARD_OFS = 8'h0c;
    localparam logic [7:0] ECHO_DUR_OFS = 8'h10;
    localparam logic [7:0] ECHO_LOCK_OFS = 8'h14;
    localparam logic [7:0] SEAL_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1c;
    localparam logic [7:0] INT_STAT_OFS = 8'h20;
    localparam logic [7:0] INT_CLR_OFS = 8'h24;
    localparam logic [7:0] INT_EN_OFS = 8'h28;
    // setting table: six timer settings from PU_DLY_OFS upward
    localparam int NUM_DLY = 6;
    localparam int IDX_PU = 0;
    localparam int IDX_PO = 1;
    localparam int IDX_GUARD = 2;
    localparam int IDX_ECHO_DUR = 3;
    localparam int IDX_ECHO_LOCK = 4;
    localparam int IDX_SEAL = 5;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SEAL_BIT = 2;
    localparam int CTRL_DIR_EN_BIT = 3;
    localparam int CTRL_NEG_SEL_BIT = 4;
    localparam int CTRL_NEU_SEL_BIT = 5;
    localparam int CTRL_OPEN_CONT_BIT = 6;
    localparam int CTRL_ECHO_EN_BIT = 7;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RST = 8'h03;
    localparam logic [15:0] DLY_RST = 16'h0004;
    // interrupt event bits
    localparam int EV_TRIP = 0;
    localparam int EV_TX = 1;
    localparam int EV_ECHO = 2;
    localparam int EV_REV = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] INT_RST = 4'h0;

    typedef enum logic [1:0] {
        MODE_DIRECT = 2'b00,
        MODE_PU = 2'b01,
        MODE_PO = 2'b10,
        MODE_OFF = 2'b11
    } ptt_mode_e;

    typedef enum logic [1:0] {
        ECHO_IDLE = 2'b00,
        ECHO_SEND = 2'b01,
        ECHO_LOCK = 2'b10
    } ptt_echo_e;
endpackage

// [hw/ptt_pickup_timer.sv]
// pickup timer: qualifies an input that stays high for a set number of ticks
`timescale 1ns/1ps
module ptt_pickup_timer #(
    parameter int TW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic tick,
    input wire logic din,
    input wire logic [TW-1:0] delay,
    output logic qual
);
    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cnt_nxt;
    logic qual_r;
    logic qual_nxt;

    // count ticks while the input holds; any drop restarts the wait
    always_comb
    begin
        cnt_nxt = cnt_r;
        qual_nxt = 1'b0;
        if (clr || !din)
        begin
            cnt_nxt = '0;
        end
        else
        begin
            qual_nxt = (cnt_r >= delay);
            if (tick && cnt_r < delay)
            begin
                cnt_nxt = cnt_r + TW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            qual_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign qual = qual_r;

    a_qual_needs_hold: assert property (@(posedge pclk) disable iff (!presetn)
        qual_r |-> $past(din) && $past(cnt_r) >= $past(delay)) // [RULE6]
        else $error("pickup qualified before the delay ran out");
endmodule // ptt_pickup_timer

// [hw/ptt_echo.sv]
// echo sequencer: one timed echo, then a lockout before the next
`timescale 1ns/1ps
module ptt_echo #(
    parameter int TW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic tick,
    input wire logic start,
    input wire logic [TW-1:0] dur,
    input wire logic [TW-1:0] lock,
    output logic echo_active,
    output logic echo_start
);
    ptt_pkg::ptt_echo_e st_r;
    ptt_pkg::ptt_echo_e st_nxt;
    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cnt_nxt;

    // idle -> send for dur ticks -> lockout for lock ticks -> idle
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        echo_start = 1'b0;
        unique case (st_r)
            ptt_pkg::ECHO_IDLE:
            begin
                cnt_nxt = '0;
                if (start)
                begin
                    st_nxt = ptt_pkg::ECHO_SEND; // [RULE9]
                    echo_start = 1'b1;
                end
            end
            ptt_pkg::ECHO_SEND:
            begin
                if (cnt_r >= dur)
                begin
                    st_nxt = ptt_pkg::ECHO_LOCK; // [RULE10]
                    cnt_nxt = '0;
                end
                else if (tick)
                begin
                    cnt_nxt = cnt_r + TW'(1);
                end
            end
            ptt_pkg::ECHO_LOCK:
            begin
                if (cnt_r >= lock)
                begin
                    st_nxt = ptt_pkg::ECHO_IDLE;
                    cnt_nxt = '0;
                end
                else if (tick)
                begin
                    cnt_nxt = cnt_r + TW'(1);
                end
            end
            default:
            begin
                st_nxt = ptt_pkg::ECHO_IDLE;
                cnt_nxt = '0;
            end
        endcase
        if (clr)
        begin
            st_nxt = ptt_pkg::ECHO_IDLE; // [RULE15]
            cnt_nxt = '0;
            echo_start = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= ptt_pkg::ECHO_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign echo_active = (st_r == ptt_pkg::ECHO_SEND);

    a_echo_to_lock: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ptt_pkg::ECHO_SEND && cnt_r >= dur && !clr
        |=> st_r == ptt_pkg::ECHO_LOCK) // [RULE10]
        else $error("echo did not enter lockout when its duration ended");
    a_lock_no_echo: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ptt_pkg::ECHO_LOCK |=> st_r != ptt_pkg::ECHO_SEND) // [RULE10]
        else $error("echo restarted during lockout");
endmodule // ptt_echo

// [hw/ptt_scheme.sv]
// pilot transfer trip schemes: direct, permissive under- and over-reach
// Overview of operation
// [RULE1] direct mode: zone 1 pickup keys transmit
// [RULE2] direct mode: receive trips without local supervision
// [RULE3] direct mode: optional transmit seal-in after keying
// [RULE4] pu mode: zone 1 pickup keys transmit
// [RULE5] pu mode: trip needs qualified receive and zone 2
// [RULE6] pu mode: receive qualified after continuous pickup delay
// [RULE7] po mode: zone 2 or directional signal keys
// [RULE8] po mode: trip on qualified receive plus forward
// [RULE9] open terminal: echo received permissive once, timed
// [RULE10] lockout after echo stops further echoes
// [RULE11] option: send continuously while terminal open
// [RULE12] po mode: receive needs settable pickup delay
// [RULE13] reversal blocking on directional path, not zone 2
// [RULE14] guard time for forward pickup after receive
// [RULE15] timers count ticks; sync reset clears all
// [RULE16] one mode active; other outputs stay low
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module ptt_scheme #(
    parameter int TW = 16,
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pass_tick,
    input wire logic scheme_reset,
    input wire logic zone1_phase,
    input wire logic zone1_ground,
    input wire logic zone2_phase,
    input wire logic zone2_ground,
    input wire logic negative_sequence_forward_flag,
    input wire logic neutral_forward_flag,
    input wire logic remote_receive,
    input wire logic terminal_open,
    output logic direct_mode_transmit,
    output logic direct_mode_operate,
    output logic pu_mode_transmit,
    output logic pu_mode_operate,
    output logic po_mode_transmit,
    output logic po_mode_operate,
    output logic irq
);
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [TW-1:0] dly_r [0:ptt_pkg::NUM_DLY-1];
    logic [TW-1:0] dly_nxt [0:ptt_pkg::NUM_DLY-1];
    logic [3:0] int_stat_r, int_stat_nxt;
    logic [3:0] int_en_r, int_en_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic irq_r, irq_nxt;
    logic [5:0] out_r, out_nxt; // {po_op, po_tx, pu_op, pu_tx, dir_op, dir_tx}
    logic [TW-1:0] seal_cnt_r, seal_cnt_nxt;
    logic reversal_r, reversal_nxt;
    ptt_pkg::ptt_mode_e mode;
    logic z1, z2, dir_fwd, dir_key, pu_qual, po_qual, rev_pick;
    logic echo_active, echo_start, echo_req, open_cont;
    logic setup, wr_en, mapped;
    logic [3:0] ev;
    logic [7:0] ofs;

    assign ofs = 8'(paddr);
    assign mode = ptt_pkg::ptt_mode_e'(ctrl_r[ptt_pkg::CTRL_MODE_LSB +: 2]);
    assign z1 = zone1_phase | zone1_ground;
    assign z2 = zone2_phase | zone2_ground;
    // supplementary forward signal from the selected directional elements
    assign dir_fwd = ctrl_r[ptt_pkg::CTRL_DIR_EN_BIT]
        & ((ctrl_r[ptt_pkg::CTRL_NEG_SEL_BIT] & negative_sequence_forward_flag)
        | (ctrl_r[ptt_pkg::CTRL_NEU_SEL_BIT] & neutral_forward_flag));
    assign dir_key = dir_fwd & ~reversal_r; // [RULE13]
    assign open_cont = ctrl_r[ptt_pkg::CTRL_OPEN_CONT_BIT];
    assign echo_req = ctrl_r[ptt_pkg::CTRL_ECHO_EN_BIT] & ~open_cont
        & terminal_open & po_qual; // [RULE9]

    // receive qualification for each permissive mode
    ptt_pickup_timer #(.TW(TW)) u_pu_rx (
        .pclk(pclk),
        .presetn(presetn),
        .clr(scheme_reset || mode != ptt_pkg::MODE_PU),
        .tick(pass_tick),
        .din(remote_receive),
        .delay(dly_r[ptt_pkg::IDX_PU]),
        .qual(pu_qual)
    ); // [RULE6]
    ptt_pickup_timer #(.TW(TW)) u_po_rx (
        .pclk(pclk),
        .presetn(presetn),
        .clr(scheme_reset || mode != ptt_pkg::MODE_PO),
        .tick(pass_tick),
        .din(remote_receive),
        .delay(dly_r[ptt_pkg::IDX_PO]),
        .qual(po_qual)
    ); // [RULE12]
    // guard: receive present but no forward pickup for the whole guard time
    ptt_pickup_timer #(.TW(TW)) u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .clr(scheme_reset || mode != ptt_pkg::MODE_PO),
        .tick(pass_tick),
        .din(remote_receive & ~dir_fwd),
        .delay(dly_r[ptt_pkg::IDX_GUARD]),
        .qual(rev_pick)
    ); // [RULE14]
    ptt_echo #(.TW(TW)) u_echo (
        .pclk(pclk),
        .presetn(presetn),
        .clr(scheme_reset || mode != ptt_pkg::MODE_PO),
        .tick(pass_tick),
        .start(echo_req),
        .dur(dly_r[ptt_pkg::IDX_ECHO_DUR]),
        .lock(dly_r[ptt_pkg::IDX_ECHO_LOCK]),
        .echo_active(echo_active),
        .echo_start(echo_start)
    );

    // scheme logic; only the selected mode drives its pair of outputs
    always_comb
    begin
        out_nxt = 6'h00;
        seal_cnt_nxt = seal_cnt_r;
        reversal_nxt = remote_receive & (reversal_r | rev_pick); // [RULE14]
        if (z1 && ctrl_r[ptt_pkg::CTRL_SEAL_BIT])
        begin
            seal_cnt_nxt = dly_r[ptt_pkg::IDX_SEAL]; // [RULE3]
        end
        else if (pass_tick && seal_cnt_r != '0)
        begin
            seal_cnt_nxt = seal_cnt_r - TW'(1); // [RULE15]
        end
        unique case (mode)
            ptt_pkg::MODE_DIRECT:
            begin
                out_nxt[0] = z1 | (seal_cnt_r != '0); // [RULE1] [RULE3]
                out_nxt[1] = remote_receive; // [RULE2]
            end
            ptt_pkg::MODE_PU:
            begin
                out_nxt[2] = z1; // [RULE4]
                out_nxt[3] = pu_qual & z2; // [RULE5]
            end
            ptt_pkg::MODE_PO:
            begin
                // zone 2 keys unconditionally; only the directional path is blocked
                out_nxt[4] = z2 | dir_key | echo_active
                    | (open_cont & terminal_open); // [RULE7] [RULE11] [RULE13]
                out_nxt[5] = po_qual & (z2 | dir_key); // [RULE8] [RULE12]
            end
            ptt_pkg::MODE_OFF:
            begin
                out_nxt = 6'h00; // [RULE16]
            end
        endcase
        if (mode != ptt_pkg::MODE_DIRECT)
        begin
            seal_cnt_nxt = '0;
        end
        if (mode != ptt_pkg::MODE_PO)
        begin
            reversal_nxt = 1'b0;
        end
        if (scheme_reset)
        begin
            out_nxt = 6'h00; // [RULE15]
            seal_cnt_nxt = '0;
            reversal_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_r <= 6'h00;
            seal_cnt_r <= '0;
            reversal_r <= 1'b0;
        end
        else
        begin
            out_r <= out_nxt;
            seal_cnt_r <= seal_cnt_nxt;
            reversal_r <= reversal_nxt;
        end
    end

    // events: rising trip, rising transmit, echo start, reversal onset
    assign ev[ptt_pkg::EV_TRIP] = |{out_nxt[5], out_nxt[3], out_nxt[1]}
        & ~|{out_r[5], out_r[3], out_r[1]};
    assign ev[ptt_pkg::EV_TX] = |{out_nxt[4], out_nxt[2], out_nxt[0]}
        & ~|{out_r[4], out_r[2], out_r[0]};
    assign ev[ptt_pkg::EV_ECHO] = echo_start;
    assign ev[ptt_pkg::EV_REV] = reversal_nxt & ~reversal_r;

    // apb slave: no wait states, answer registered at the setup edge
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign mapped = (ofs <= ptt_pkg::INT_EN_OFS) && (ofs[1:0] == 2'b00);

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        int_en_nxt = int_en_r;
        for (int i = 0; i < ptt_pkg::NUM_DLY; i++)
        begin
            dly_nxt[i] = dly_r[i];
        end
        pready_nxt = setup;
        pslverr_nxt = setup & ~mapped;
        prdata_nxt = prdata_r;
        // a clear in the same cycle as a new event loses to the event
        int_stat_nxt = int_stat_r | ev;
        if (setup && !pwrite)
        begin
            prdata_nxt = 32'h0000_0000;
            case (ofs)
                ptt_pkg::CTRL_OFS: prdata_nxt = 32'(ctrl_r);
                ptt_pkg::STAT_OFS: prdata_nxt = 32'({reversal_r, echo_active, out_r});
                ptt_pkg::INT_STAT_OFS: prdata_nxt = 32'(int_stat_r);
                ptt_pkg::INT_EN_OFS: prdata_nxt = 32'(int_en_r);
                default:
                begin
                    for (int i = 0; i < ptt_pkg::NUM_DLY; i++)
                    begin
                        if (ofs == ptt_pkg::PU_DLY_OFS + 8'(4 * i))
                        begin
                            prdata_nxt = 32'(dly_r[i]);
                        end
                    end
                end
            endcase
        end
        if (wr_en)
        begin
            case (ofs)
                ptt_pkg::CTRL_OFS: ctrl_nxt = pwdata[7:0];
                ptt_pkg::INT_CLR_OFS: int_stat_nxt = (int_stat_r & ~pwdata[3:0]) | ev;
                ptt_pkg::INT_EN_OFS: int_en_nxt = pwdata[3:0];
                default:
                begin
                    for (int i = 0; i < ptt_pkg::NUM_DLY; i++)
                    begin
                        if (ofs == ptt_pkg::PU_DLY_OFS + 8'(4 * i))
                        begin
                            dly_nxt[i] = pwdata[TW-1:0];
                        end
                    end
                end
            endcase
        end
        irq_nxt = |(int_stat_nxt & int_en_nxt);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= ptt_pkg::CTRL_RST;
            int_en_r <= ptt_pkg::INT_RST;
            int_stat_r <= ptt_pkg::INT_RST;
            for (int i = 0; i < ptt_pkg::NUM_DLY; i++)
            begin
                dly_r[i] <= TW'(ptt_pkg::DLY_RST);
            end
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            int_en_r <= int_en_nxt;
            int_stat_r <= int_stat_nxt;
            for (int i = 0; i < ptt_pkg::NUM_DLY; i++)
            begin
                dly_r[i] <= dly_nxt[i];
            end
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign direct_mode_transmit = out_r[0];
    assign direct_mode_operate = out_r[1];
    assign pu_mode_transmit = out_r[2];
    assign pu_mode_operate = out_r[3];
    assign po_mode_transmit = out_r[4];
    assign po_mode_operate = out_r[5];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_po_open;
        mode == ptt_pkg::MODE_PO && !scheme_reset;
    endsequence

    a_direct_key: assert property (mode == ptt_pkg::MODE_DIRECT && z1 && !scheme_reset
        |=> direct_mode_transmit) // [RULE1]
        else $error("direct mode transmit missing on zone 1");
    a_direct_trip: assert property (mode == ptt_pkg::MODE_DIRECT && remote_receive
        && !scheme_reset |=> direct_mode_operate) // [RULE2]
        else $error("direct mode did not trip on receive");
    a_seal_hold: assert property (mode == ptt_pkg::MODE_DIRECT && seal_cnt_r != '0
        && !scheme_reset |=> direct_mode_transmit) // [RULE3]
        else $error("seal-in did not hold transmit");
    a_pu_key: assert property (mode == ptt_pkg::MODE_PU && z1 && !scheme_reset
        |=> pu_mode_transmit) // [RULE4]
        else $error("pu mode transmit missing on zone 1");
    a_pu_trip: assert property (pu_mode_operate |-> $past(pu_qual) && $past(z2)) // [RULE5]
        else $error("pu mode tripped without qualified receive and zone 2");
    a_po_key: assert property (s_po_open and z2 |=> po_mode_transmit) // [RULE7]
        else $error("po mode transmit missing on zone 2");
    a_po_trip: assert property (po_mode_operate
        |-> $past(po_qual) && ($past(z2) || $past(dir_key))) // [RULE8] [RULE12]
        else $error("po mode tripped without qualified receive and forward");
    a_open_cont: assert property (s_po_open and (open_cont && terminal_open)
        |=> po_mode_transmit) // [RULE11]
        else $error("continuous send missing for open terminal");
    a_rev_block: assert property (reversal_r && mode == ptt_pkg::MODE_PO && !z2
        && !echo_active && !(open_cont && terminal_open) && !scheme_reset
        |=> !po_mode_transmit) // [RULE13]
        else $error("directional keying not blocked during reversal");
    a_echo_send: assert property (s_po_open ##1 (echo_active && !scheme_reset)
        |=> po_mode_transmit) // [RULE9]
        else $error("echo did not key transmit");
    a_reset_clear: assert property (scheme_reset |=> out_r == 6'h00 && seal_cnt_r == '0) // [RULE15]
        else $error("sync reset left outputs or seal-in active");
    a_one_mode: assert property ($onehot0({|out_r[5:4], |out_r[3:2], |out_r[1:0]})) // [RULE16]
        else $error("more than one scheme drives outputs");
endmodule // ptt_scheme

// [verif/ptt_remote.sv]
// remote terminal model: keys the received permissive after a channel delay
`timescale 1ns/1ps
module ptt_remote (
    input wire logic pclk,
    input wire logic key,
    input wire logic [3:0] slow,
    output logic rx
);
    logic [3:0] cnt_r = 4'h0;

    // channel latency of slow plus one cycles; dropping the key clears the line at once
    always_ff @(posedge pclk)
    begin
        if (key == 1'b0)
        begin
            cnt_r <= 4'h0;
            rx <= 1'b0;
        end
        else if (cnt_r >= slow)
            rx <= 1'b1;
        else
            cnt_r <= cnt_r + 4'h1;
    end
endmodule // ptt_remote

// [verif/tb_ptt_scheme.sv]
// self-checking bench for the pilot transfer trip scheme block
`timescale 1ns/1ps
module tb_ptt_scheme;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_v, v;
    logic pready, pslverr, err_v, irq, rx, sel = 1'b0, tick = 1'b0, srst = 1'b0;
    logic z1 = 1'b0, z2 = 1'b0, fwd = 1'b0, key = 1'b0, topen = 1'b0;
    logic [3:0] slow = 4'h0;
    logic [5:0] outs;
    int errors = 0, tests_run = 0, m;

    // 4 ns clock; ticks and pickup routing are random so every input path is used
    always #2 pclk = ~pclk;
    always @(posedge pclk)
    begin
        tick <= 1'($urandom);
        sel <= 1'($urandom);
    end

    ptt_remote rem_u (.pclk(pclk), .key(key), .slow(slow), .rx(rx));
    ptt_scheme dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pass_tick(tick), .scheme_reset(srst),
        .zone1_phase(z1 & sel), .zone1_ground(z1 & ~sel), .zone2_phase(z2 & ~sel),
        .zone2_ground(z2 & sel), .negative_sequence_forward_flag(fwd & sel),
        .neutral_forward_flag(fwd & ~sel), .remote_receive(rx), .terminal_open(topen),
        .direct_mode_transmit(outs[0]), .direct_mode_operate(outs[1]),
        .pu_mode_transmit(outs[2]), .pu_mode_operate(outs[3]),
        .po_mode_transmit(outs[4]), .po_mode_operate(outs[5]), .irq(irq));

    task automatic end_of_test();
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // one apb transfer; data and error are taken only at the edge with pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!(pready === 1'b1 && penable === 1'b1) && n < 50);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50)
        begin
            chk("pready", 1, 0);
            end_of_test();
        end
    endtask

    // dis turns the directional keying enable off; both flags stay selected
    task automatic wctl(input int md, input int seal, input int echo, input int cont,
        input int dis = 0);
        apb(1'b1, ptt_pkg::CTRL_OFS,
            32'(md | seal << 2 | (32'h38 ^ dis << 3) | cont << 6 | echo << 7));
    endtask

    task automatic drive(input logic a, input logic b, input logic c, input logic f);
        @(posedge pclk);
        z1 <= a;
        z2 <= b;
        key <= c;
        fwd <= f;
    endtask

    // bounded wait for one scheme output to reach a level
    task automatic wait_out(input int b, input logic lv);
        int n;
        n = 0;
        while (outs[b] !== lv && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        chk("output level", 32'(lv), 32'(outs[b]));
        if (n == 200)
            end_of_test();
    endtask

    // settled outputs for held inputs; receive held long enough to qualify
    function automatic logic [5:0] model(int md, int a, int b, int r, int f);
        logic [5:0] o;
        o[0] = md == 0 && a != 0;
        o[1] = md == 0 && r != 0;
        o[2] = md == 1 && a != 0;
        o[3] = md == 1 && r != 0 && b != 0;
        o[4] = md == 2 && (b != 0 || f != 0);
        o[5] = md == 2 && r != 0 && (b != 0 || f != 0);
        return o;
    endfunction

    initial
    begin
        void'($urandom(32'h09cee0ec));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ptt_pkg::CTRL_OFS, 0);
        chk("ctrl", 32'(ptt_pkg::CTRL_RST), rd_v);
        chk("outs", 0, 32'(outs));
        for (int k = 0; k < ptt_pkg::NUM_DLY; k++)
        begin
            apb(1'b0, ptt_pkg::PU_DLY_OFS + 8'(4 * k), 0);
            chk("delay", 32'(ptt_pkg::DLY_RST), rd_v);
            v = 2 + $urandom % 4;
            apb(1'b1, ptt_pkg::PU_DLY_OFS + 8'(4 * k), v);
            apb(1'b0, ptt_pkg::PU_DLY_OFS + 8'(4 * k), 0);
            chk("delay", v, rd_v);
        end
        apb(1'b0, 8'h30, 0);
        chk("slverr", 1, 32'(err_v));
        // seal-in holds transmit after zone 1 drops; scheme reset clears it
        wctl(0, 1, 0, 0);
        drive(1, 0, 0, 0);
        repeat (3) @(posedge pclk);
        drive(0, 0, 0, 0);
        repeat (2) @(posedge pclk);
        chk("seal", 1, 32'(outs[0]));
        srst <= 1'b1;
        @(posedge pclk);
        srst <= 1'b0;
        @(posedge pclk);
        chk("sreset", 0, 32'(outs));
        // unsupervised direct trip raises the trip event, then mask and clear
        apb(1'b1, ptt_pkg::INT_EN_OFS, 1);
        drive(0, 0, 1, 0);
        wait_out(1, 1'b1);
        repeat (3) @(posedge pclk);
        chk("irq", 1, 32'(irq));
        apb(1'b1, ptt_pkg::INT_EN_OFS, 0);
        @(posedge pclk);
        chk("irq masked", 0, 32'(irq));
        apb(1'b0, ptt_pkg::INT_STAT_OFS, 0);
        chk("int status", 1, rd_v & 32'h1);
        apb(1'b1, ptt_pkg::INT_EN_OFS, 1);
        drive(0, 0, 0, 0);
        apb(1'b1, ptt_pkg::INT_CLR_OFS, 32'hf);
        @(posedge pclk);
        chk("irq cleared", 0, 32'(irq));
        // random pickups per mode; inputs cleared first so no latch carries over
        for (int i = 0; i < 24; i++)
        begin
            m = i % 3;
            v = $urandom;
            drive(0, 0, 0, 0);
            wctl(m, 0, 0, 0, v[8]);
            repeat (10) @(posedge pclk);
            slow <= v[7:4];
            drive(v[0], v[1], v[2], v[3]);
            // channel latency plus up to five random ticks needs the longer settle
            repeat (60) @(posedge pclk);
            chk("outs", 32'(model(m, v[0], v[1], v[2], v[3] & ~v[8])), 32'(outs));
        end
        // a one-cycle receive glitch must not qualify
        drive(0, 0, 0, 0);
        slow <= 4'h0;
        wctl(1, 0, 0, 0);
        drive(0, 1, 1, 0);
        drive(0, 1, 0, 0);
        repeat (20) @(posedge pclk);
        chk("glitch", 0, 32'(outs[3]));
        // receive with no forward indication latches reversal on the directional path
        drive(0, 0, 0, 0);
        wctl(2, 0, 0, 0);
        drive(0, 0, 1, 0);
        repeat (60) @(posedge pclk);
        drive(0, 0, 1, 1);
        repeat (10) @(posedge pclk);
        chk("reversal", 0, 32'(outs[5:4]));
        drive(0, 1, 1, 1);
        repeat (10) @(posedge pclk);
        chk("zone2 path", 3, 32'(outs[5:4]));
        // open terminal: one timed echo, lockout, then continuous send option
        drive(0, 0, 0, 0);
        wctl(2, 0, 1, 0);
        topen <= 1'b1;
        drive(0, 0, 1, 0);
        wait_out(4, 1'b1);
        wait_out(4, 1'b0);
        // a missing lockout would re-key within three edges of the echo ending
        repeat (3) @(posedge pclk);
        chk("lockout", 0, 32'(outs[4]));
        wctl(2, 0, 0, 1);
        repeat (60) @(posedge pclk);
        chk("continuous", 1, 32'(outs[4]));
        end_of_test();
    end
endmodule // tb_ptt_scheme
